// file: rtl/crs_pkg.sv
// constants and carriers for the cpu register set
// assumes one 10 MHz clock and an active low asynchronous reset
package crs_pkg;
    // flag bit positions
    localparam int unsigned FLG_W = 11;
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_D = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_S = 3;
    localparam int unsigned FLG_B = 4;
    localparam int unsigned FLG_O = 5;
    localparam int unsigned FLG_I = 6;
    localparam int unsigned FLG_U = 7;
    localparam int unsigned IPL_LSB = 8;
    localparam int unsigned IPL_W = 3;
    // reset values
    localparam logic [10:0] FLG_RST = 11'h000;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [19:0] LONG_RST = 20'h0_0000;
    // lowest software vector that keeps the stack select
    localparam logic [5:0] SW_VEC_KEEP = 6'h20;
    // bus byte offsets
    localparam logic [6:0] OFS_D0 = 7'h00;
    localparam logic [6:0] OFS_D1 = 7'h04;
    localparam logic [6:0] OFS_D2 = 7'h08;
    localparam logic [6:0] OFS_D3 = 7'h0C;
    localparam logic [6:0] OFS_A0 = 7'h10;
    localparam logic [6:0] OFS_A1 = 7'h14;
    localparam logic [6:0] OFS_FB = 7'h18;
    localparam logic [6:0] OFS_SB = 7'h1C;
    localparam logic [6:0] OFS_VTB = 7'h20;
    localparam logic [6:0] OFS_PC = 7'h24;
    localparam logic [6:0] OFS_USP = 7'h28;
    localparam logic [6:0] OFS_ISP = 7'h2C;
    localparam logic [6:0] OFS_FLG = 7'h30;
    localparam logic [6:0] OFS_SP = 7'h34;
    localparam logic [6:0] OFS_DPL = 7'h38;
    localparam logic [6:0] OFS_DPH = 7'h3C;
    localparam logic [6:0] OFS_APL = 7'h40;

    typedef enum logic [3:0] {
        SEL_D0 = 4'h0, SEL_D1 = 4'h1, SEL_D2 = 4'h2, SEL_D3 = 4'h3,
        SEL_A0 = 4'h4, SEL_A1 = 4'h5, SEL_FB = 4'h6, SEL_SB = 4'h7,
        SEL_VTB = 4'h8, SEL_PC = 4'h9, SEL_USP = 4'hA, SEL_ISP = 4'hB,
        SEL_FLG = 4'hC, SEL_SP = 4'hD
    } crs_sel_e;

    typedef enum logic [1:0] {
        SZ_LO = 2'b00, SZ_HI = 2'b01, SZ_WORD = 2'b10, SZ_LONG = 2'b11
    } crs_size_e;

    // core register write
    typedef struct packed {
        logic en;
        crs_sel_e sel;
        crs_size_e size;
        logic [31:0] data;
    } crs_wr_s;

    // alu result for the condition flags
    typedef struct packed {
        logic upd;
        logic upd_c;
        logic upd_zs;
        logic upd_o;
        logic byte_op;
        logic carry;
        logic ovf;
        logic [15:0] result;
    } crs_alu_s;

    // pending interrupt request
    typedef struct packed {
        logic req;
        logic maskable;
        logic [2:0] prio;
    } crs_irq_s;

    // decoded bus target
    typedef struct packed {
        logic hit;
        crs_sel_e sel;
        logic long_op;
    } crs_tgt_s;
endpackage

// file: rtl/crs_flag_unit.sv
// processor flag register with alu and interrupt updates
// assumes callers never present two full writes in one cycle
`timescale 1ns/10ps
module crs_flag_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // full write
    input wire logic wr_en,
    input wire logic [10:0] wr_data,
    // alu and interrupt events
    input wire crs_pkg::crs_alu_s alu,
    input wire logic hw_ack,
    input wire logic sw_int,
    input wire logic [5:0] sw_vec,
    // state
    output logic [10:0] flags_q
);
    import crs_pkg::*;

    logic zero_v;
    logic sign_v;

    // zero and sign follow the operand width
    assign zero_v = alu.byte_op ? (alu.result[7:0] == 8'h00) : (alu.result == 16'h0000);
    assign sign_v = alu.byte_op ? alu.result[7] : alu.result[15];

    // later assignments win: write, then alu, then interrupt
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_q <= FLG_RST;
        end else begin
            if (wr_en) begin
                flags_q <= wr_data;
            end
            if (alu.upd && alu.upd_c) begin
                flags_q[FLG_C] <= alu.carry;
            end
            if (alu.upd && alu.upd_zs) begin
                flags_q[FLG_Z] <= zero_v;
                flags_q[FLG_S] <= sign_v;
            end
            if (alu.upd && alu.upd_o) begin
                flags_q[FLG_O] <= alu.ovf;
            end
            if (hw_ack || sw_int) begin
                flags_q[FLG_I] <= 1'b0;
            end
            if (hw_ack || (sw_int && sw_vec < SW_VEC_KEEP)) begin
                flags_q[FLG_U] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_ack_clears_ie: assert property ((hw_ack || sw_int) |=> !flags_q[FLG_I])
        else $error("interrupt enable not cleared on acknowledge");
    a_stack_sel_clear: assert property (
        (hw_ack || (sw_int && sw_vec < 6'h20)) |=> !flags_q[FLG_U])
        else $error("stack select not cleared");
    a_stack_sel_keep: assert property (
        (sw_int && sw_vec >= 6'h20 && !hw_ack && !wr_en) |=> $stable(flags_q[FLG_U]))
        else $error("stack select changed by upper software vector");
    a_zero_flag: assert property (
        (alu.upd && alu.upd_zs && !alu.byte_op) |=>
        flags_q[FLG_Z] == ($past(alu.result) == 16'h0000))
        else $error("zero flag wrong");
    a_sign_flag: assert property (
        (alu.upd && alu.upd_zs && !alu.byte_op) |=>
        flags_q[FLG_S] == $past(alu.result[15]))
        else $error("sign flag wrong");
endmodule

// file: rtl/crs_regfile.sv
// banked cpu register set with avalon-mm access
// assumes the execution core drives its ports from the same clock
`timescale 1ns/10ps

// Function
// - sixteen-bit data registers; first two split bytewise
// - third, fourth data registers form upper long halves
// - two address registers, second pairs as upper
// - frame base register supplies frame-relative base
// - static base register supplies static-relative base
// - twenty-bit vector table base register
// - twenty-bit program counter holds next instruction
// - interrupt stack when select clear, else user
// - acknowledge or low software vector clears select
// - eleven-bit flag register shows processor state
// - carry flag keeps alu carry, borrow, shift-out
// - zero flag set when result is zero
// - sign flag set when result is negative
// - bank flag picks register bank zero or one
// - overflow flag set on operation overflow
// - interrupt enable flag gates maskable interrupts
// - any acknowledge clears interrupt enable flag
// - accept only priority above three-bit level
// - reserved flag bit reads undefined, write zero
module crs_regfile (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // core register access
    input wire crs_pkg::crs_wr_s core_wr,
    input wire crs_pkg::crs_sel_e core_rd_sel,
    input wire crs_pkg::crs_size_e core_rd_size,
    output logic [31:0] core_rd_data_q,
    // alu flags and interrupts
    input wire crs_pkg::crs_alu_s alu,
    input wire crs_pkg::crs_irq_s irq,
    output logic irq_accept,
    input wire logic hw_ack,
    input wire logic sw_int,
    input wire logic [5:0] sw_vec,
    // addressing state
    output logic [19:0] program_counter,
    output logic [19:0] vector_table_base,
    output logic [15:0] frame_base,
    output logic [15:0] static_base,
    output logic [15:0] stack_pointer,
    output logic [10:0] processor_flag_register
);
    import crs_pkg::*;

    logic [15:0] gpr_q [2][7];
    logic [15:0] sb_q;
    logic [15:0] usp_q;
    logic [15:0] isp_q;
    logic [19:0] vtb_q;
    logic [19:0] pc_q;
    logic [10:0] flags;
    logic bank;
    logic [2:0] processor_priority_level;
    logic ack_q;
    logic bus_req;
    logic busy;
    logic bus_done;
    crs_tgt_s bus_tgt;
    logic w_go;
    crs_sel_e w_sel;
    logic w_long;
    logic [31:0] w_data;
    logic [3:0] w_be;
    logic [31:0] bus_rd;
    logic [31:0] core_rd;
    logic [15:0] flg_wr;

    // byte-lane merge of a sixteen-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // byte-lane merge of a twenty-bit register
    function automatic logic [19:0] merge20(input logic [19:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
        merge20 = {be[2] ? nw[19:16] : old[19:16], merge16(old[15:0], nw[15:0], be[1:0])};
    endfunction

    // bank slot holding the upper half of a long pair
    function automatic logic [2:0] partner(input logic [2:0] idx);
        partner = (idx == 3'd4) ? 3'd5 : 3'(idx + 3'd2);
    endfunction

    // register value seen by a read of one selector
    function automatic logic [31:0] read_sel(input crs_sel_e sel, input logic long_op);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (sel)
            SEL_D0, SEL_D1, SEL_A0: begin
                v[15:0] = gpr_q[bank][sel[2:0]];
                if (long_op) begin
                    v[31:16] = gpr_q[bank][partner(sel[2:0])];
                end
            end
            SEL_D2, SEL_D3, SEL_A1, SEL_FB: begin
                v[15:0] = gpr_q[bank][sel[2:0]];
            end
            SEL_SB: v[15:0] = sb_q;
            SEL_VTB: v[19:0] = vtb_q;
            SEL_PC: v[19:0] = pc_q;
            SEL_USP: v[15:0] = usp_q;
            SEL_ISP: v[15:0] = isp_q;
            SEL_FLG: v[10:0] = flags;
            SEL_SP: v[15:0] = flags[FLG_U] ? usp_q : isp_q;
            default: v = 32'h0000_0000;
        endcase
        read_sel = v;
    endfunction

    // bus offset decode
    function automatic crs_tgt_s decode(input logic [6:0] a);
        crs_tgt_s t;
        t = '{hit: 1'b1, sel: SEL_D0, long_op: 1'b0};
        case (a)
            OFS_D0: t.sel = SEL_D0;
            OFS_D1: t.sel = SEL_D1;
            OFS_D2: t.sel = SEL_D2;
            OFS_D3: t.sel = SEL_D3;
            OFS_A0: t.sel = SEL_A0;
            OFS_A1: t.sel = SEL_A1;
            OFS_FB: t.sel = SEL_FB;
            OFS_SB: t.sel = SEL_SB;
            OFS_VTB: t.sel = SEL_VTB;
            OFS_PC: t.sel = SEL_PC;
            OFS_USP: t.sel = SEL_USP;
            OFS_ISP: t.sel = SEL_ISP;
            OFS_FLG: t.sel = SEL_FLG;
            OFS_SP: t.sel = SEL_SP;
            OFS_DPL: t = '{hit: 1'b1, sel: SEL_D0, long_op: 1'b1};
            OFS_DPH: t = '{hit: 1'b1, sel: SEL_D1, long_op: 1'b1};
            OFS_APL: t = '{hit: 1'b1, sel: SEL_A0, long_op: 1'b1};
            default: t.hit = 1'b0;
        endcase
        decode = t;
    endfunction

    assign bank = flags[FLG_B];
    assign processor_priority_level = flags[IPL_LSB +: IPL_W];

    // bus handshake: one wait state, stalled while the core updates state
    assign bus_req = avs_read | avs_write;
    assign busy = core_wr.en | alu.upd | hw_ack | sw_int;
    assign bus_done = bus_req & ack_q & ~busy;
    assign avs_waitrequest = bus_req & ~(ack_q & ~busy);
    assign bus_tgt = decode(avs_address);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~bus_done & ~busy;
        end
    end

    // read data captured while the request waits; unmapped reads give zero
    always_comb begin
        bus_rd = bus_tgt.hit ? read_sel(bus_tgt.sel, bus_tgt.long_op) : 32'h0000_0000;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_done) begin
            avs_readdata <= bus_rd;
        end
    end

    // one write source per cycle: core, else a finished bus write
    always_comb begin
        w_go = 1'b0;
        w_sel = core_wr.sel;
        w_long = 1'b0;
        w_data = core_wr.data;
        w_be = 4'b0000;
        if (core_wr.en) begin
            w_go = 1'b1;
            w_long = (core_wr.size == SZ_LONG);
            case (core_wr.size)
                SZ_LO: w_be = 4'b0001;
                SZ_HI: begin
                    w_be = 4'b0010;
                    w_data[15:8] = core_wr.data[7:0];
                end
                SZ_WORD: w_be = 4'b0011;
                default: w_be = 4'b1111;
            endcase
            if (core_wr.sel == SEL_VTB || core_wr.sel == SEL_PC) begin
                w_be = 4'b1111;
            end
        end else if (bus_done && avs_write && bus_tgt.hit) begin
            w_go = 1'b1;
            w_sel = bus_tgt.sel;
            w_long = bus_tgt.long_op;
            w_data = avs_writedata;
            w_be = avs_byteenable;
        end
    end

    // banked data, address and frame base registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int b = 0; b < 2; b++) begin
                for (int r = 0; r < 7; r++) begin
                    gpr_q[b][r] <= REG_RST;
                end
            end
        end else if (w_go && w_sel <= SEL_FB) begin
            // only the selected bank is touched
            gpr_q[bank][w_sel[2:0]] <= merge16(gpr_q[bank][w_sel[2:0]], w_data[15:0],
                                               w_be[1:0]);
            if (w_long && (w_sel == SEL_D0 || w_sel == SEL_D1 || w_sel == SEL_A0)) begin
                gpr_q[bank][partner(w_sel[2:0])] <= merge16(
                    gpr_q[bank][partner(w_sel[2:0])], w_data[31:16], w_be[3:2]);
            end
        end
    end

    // static base
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sb_q <= REG_RST;
        end else if (w_go && w_sel == SEL_SB) begin
            sb_q <= merge16(sb_q, w_data[15:0], w_be[1:0]);
        end
    end

    // vector table base
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vtb_q <= LONG_RST;
        end else if (w_go && w_sel == SEL_VTB) begin
            vtb_q <= merge20(vtb_q, w_data, w_be);
        end
    end

    // program counter, loaded by the core with the next address
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc_q <= LONG_RST;
        end else if (w_go && w_sel == SEL_PC) begin
            pc_q <= merge20(pc_q, w_data, w_be);
        end
    end

    // stack pointers; the alias follows the stack select flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            usp_q <= REG_RST;
            isp_q <= REG_RST;
        end else if (w_go) begin
            if (w_sel == SEL_USP || (w_sel == SEL_SP && flags[FLG_U])) begin
                usp_q <= merge16(usp_q, w_data[15:0], w_be[1:0]);
            end
            if (w_sel == SEL_ISP || (w_sel == SEL_SP && !flags[FLG_U])) begin
                isp_q <= merge16(isp_q, w_data[15:0], w_be[1:0]);
            end
        end
    end

    // core read port, registered
    always_comb begin
        core_rd = read_sel(core_rd_sel, core_rd_size == SZ_LONG);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_rd_data_q <= 32'h0000_0000;
        end else begin
            case (core_rd_size)
                SZ_LO: core_rd_data_q <= {24'h00_0000, core_rd[7:0]};
                SZ_HI: core_rd_data_q <= {24'h00_0000, core_rd[15:8]};
                SZ_WORD: core_rd_data_q <= {12'h000, core_rd[19:0]};
                default: core_rd_data_q <= core_rd;
            endcase
        end
    end

    // flag register, written through the byte-lane merge
    assign flg_wr = merge16({5'h00, flags}, w_data[15:0], w_be[1:0]);
    crs_flag_unit u_flags (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_en(w_go && w_sel == SEL_FLG),
        .wr_data(flg_wr[10:0]),
        .alu(alu),
        .hw_ack(hw_ack),
        .sw_int(sw_int),
        .sw_vec(sw_vec),
        .flags_q(flags)
    );

    // interrupt acceptance against enable flag and priority level
    assign irq_accept = irq.req && (!irq.maskable || flags[FLG_I])
                        && (irq.prio > processor_priority_level);

    // addressing outputs
    assign program_counter = pc_q;
    assign vector_table_base = vtb_q;
    assign frame_base = gpr_q[bank][3'd6];
    assign static_base = sb_q;
    assign stack_pointer = flags[FLG_U] ? usp_q : isp_q;
    assign processor_flag_register = flags;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_bus_start;
        bus_req && !ack_q && !busy;
    endsequence

    sequence s_bus_answer;
        avs_waitrequest ##1 (!avs_waitrequest || busy);
    endsequence

    a_irq_priority: assert property (irq_accept |-> irq.prio > processor_priority_level)
        else $error("interrupt accepted at or below level");
    a_irq_mask: assert property (
        (irq.req && irq.maskable && !flags[FLG_I]) |-> !irq_accept)
        else $error("masked interrupt accepted");
    a_bus_one_wait: assert property (s_bus_start |-> s_bus_answer)
        else $error("bus answer not after one wait state");
    a_pair_write: assert property (
        (core_wr.en && core_wr.sel == SEL_D0 && core_wr.size == SZ_LONG && !bank) |=>
        gpr_q[0][2] == $past(core_wr.data[31:16]) &&
        gpr_q[0][0] == $past(core_wr.data[15:0]))
        else $error("long pair not split across halves");
    a_byte_half: assert property (
        (core_wr.en && core_wr.sel == SEL_D0 && core_wr.size == SZ_LO && !bank) |=>
        gpr_q[0][0][15:8] == $past(gpr_q[0][0][15:8]) &&
        gpr_q[0][0][7:0] == $past(core_wr.data[7:0]))
        else $error("lower byte write disturbed upper byte");
    a_bank_isolate: assert property (
        (w_go && w_sel == SEL_D0 && !bank) |=> gpr_q[1][0] == $past(gpr_q[1][0]))
        else $error("write leaked into other bank");
    a_sp_select: assert property (
        (core_wr.en && core_wr.sel == SEL_SP && core_wr.size == SZ_WORD && !flags[FLG_U])
        |=> isp_q == $past(core_wr.data[15:0]) && $stable(usp_q))
        else $error("active stack pointer not interrupt stack");
    a_pc_load: assert property (
        (core_wr.en && core_wr.sel == SEL_PC) |=> pc_q == $past(core_wr.data[19:0]))
        else $error("program counter not loaded");
endmodule

// file: dv/crs_regfile_tb.sv
// self-checking bench for the banked cpu register set and flags
// assumes crs_pkg and crs_regfile are compiled first; one 10 MHz clock
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module crs_regfile_tb;
    import crs_pkg::*;
    logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, irq_accept, hw_ack, sw_int;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, core_rd_data_q;
    logic [3:0] avs_byteenable;
    logic [5:0] sw_vec;
    logic [19:0] program_counter, vector_table_base;
    logic [15:0] frame_base, static_base, stack_pointer;
    logic [10:0] processor_flag_register;
    crs_wr_s core_wr;
    crs_sel_e core_rd_sel;
    crs_size_e core_rd_size;
    crs_alu_s alu;
    crs_irq_s irq;
    int n_errors = 0;
    int num_checks = 0;

    crs_regfile u_dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_wr(core_wr), .core_rd_sel(core_rd_sel),
        .core_rd_size(core_rd_size), .core_rd_data_q(core_rd_data_q), .alu(alu), .irq(irq),
        .irq_accept(irq_accept), .hw_ack(hw_ack), .sw_int(sw_int), .sw_vec(sw_vec),
        .program_counter(program_counter), .vector_table_base(vector_table_base),
        .frame_base(frame_base), .static_base(static_base), .stack_pointer(stack_pointer),
        .processor_flag_register(processor_flag_register));

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one avalon cycle, entered just after a rising edge, held until waitrequest low
    task automatic bus_cyc(input logic wr, input logic [6:0] a, input logic [31:0] wd,
            input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            complete_run();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] x;
        bus_cyc(1'b1, a, d, be, x);
    endtask

    task automatic rd_chk(input string nm, input logic [6:0] a, input logic [31:0] ex);
        logic [31:0] x;
        bus_cyc(1'b0, a, 32'h0000_0000, 4'hF, x);
        `CHK(nm, ex, x)
    endtask

    // one-cycle core write pulse
    task automatic core_w(input crs_sel_e s, input crs_size_e z, input logic [31:0] d);
        core_wr <= '{1'b1, s, z, d};
        @(posedge clk_sys);
        core_wr <= '0;
        @(posedge clk_sys);
    endtask

    // registered core read, looked at one edge after the select
    task automatic core_rd_chk(input string nm, input crs_sel_e s, input crs_size_e z,
            input logic [31:0] ex);
        core_rd_sel <= s;
        core_rd_size <= z;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(nm, ex, core_rd_data_q)
        @(posedge clk_sys);
    endtask

    // one-cycle alu result with all flag updates enabled
    task automatic alu_op(input logic c, input logic o, input logic [15:0] r);
        alu <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, c, o, r};
        @(posedge clk_sys);
        alu <= '0;
        @(posedge clk_sys);
    endtask

    // hardware acknowledge or software interrupt pulse
    task automatic int_pulse(input logic hw, input logic [5:0] v);
        hw_ack <= hw;
        sw_int <= !hw;
        sw_vec <= v;
        @(posedge clk_sys);
        hw_ack <= 1'b0;
        sw_int <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic irq_chk(input logic m, input logic [2:0] p, input logic ex);
        irq <= '{1'b1, m, p};
        @(negedge clk_sys);
        `CHK("irq_accept", ex, irq_accept)
        @(posedge clk_sys);
    endtask

    task automatic t_reset;
        rd_chk("flags", OFS_FLG, 32'h0000_0000);
        rd_chk("pc", OFS_PC, 32'h0000_0000);
        `CHK("flag out", 11'h000, processor_flag_register)
    endtask

    // byte lanes, long pairs and a core upper-byte write
    task automatic t_words;
        wr(OFS_D1, 32'h0000_1234, 4'h3);
        wr(OFS_D1, 32'h0000_5600, 4'h2);
        rd_chk("d1 byte", OFS_D1, 32'h0000_5634);
        core_w(SEL_D1, SZ_HI, 32'h0000_0077);
        rd_chk("d1 hi", OFS_D1, 32'h0000_7734);
        wr(OFS_DPL, 32'hDDDD_CCCC, 4'hF);
        rd_chk("d0", OFS_D0, 32'h0000_CCCC);
        rd_chk("d2", OFS_D2, 32'h0000_DDDD);
        wr(OFS_DPH, 32'h3333_1111, 4'hF);
        rd_chk("d3", OFS_D3, 32'h0000_3333);
        wr(OFS_APL, 32'hAAAA_BBBB, 4'hF);
        rd_chk("a0", OFS_A0, 32'h0000_BBBB);
        rd_chk("a1", OFS_A1, 32'h0000_AAAA);
        rd_chk("a pair", OFS_APL, 32'hAAAA_BBBB);
    endtask

    // twenty-bit registers, static base and an unmapped place
    task automatic t_long;
        wr(OFS_PC, 32'hFFFF_FFFF, 4'hF);
        rd_chk("pc", OFS_PC, 32'h000F_FFFF);
        `CHK("pc out", 20'hF_FFFF, program_counter)
        wr(OFS_VTB, 32'h000A_BCDE, 4'hF);
        `CHK("vtb out", 20'hA_BCDE, vector_table_base)
        wr(OFS_SB, 32'h0000_5A5A, 4'h3);
        `CHK("sb out", 16'h5A5A, static_base)
        wr(7'h44, 32'h1234_5678, 4'hF);
        rd_chk("unmapped", 7'h44, 32'h0000_0000);
    endtask

    // each bank keeps its own data and frame registers
    task automatic t_bank;
        wr(OFS_FB, 32'h0000_F0F0, 4'h3);
        wr(OFS_FLG, 32'h0000_0010, 4'h3);
        rd_chk("d0 bank1", OFS_D0, 32'h0000_0000);
        `CHK("fb bank1", 16'h0000, frame_base)
        wr(OFS_D0, 32'h0000_2222, 4'h3);
        wr(OFS_FLG, 32'h0000_0000, 4'h3);
        rd_chk("d0 bank0", OFS_D0, 32'h0000_CCCC);
        `CHK("fb bank0", 16'hF0F0, frame_base)
    endtask

    // reserved bit, enable flag and priority comparison
    task automatic t_flags_irq;
        wr(OFS_FLG, 32'h0000_0BC0, 4'h3);
        rd_chk("flags", OFS_FLG, 32'h0000_03C0);
        irq_chk(1'b1, 3'h4, 1'b1);
        irq_chk(1'b1, 3'h3, 1'b0);
        wr(OFS_FLG, 32'h0000_0380, 4'h3);
        irq_chk(1'b1, 3'h7, 1'b0);
        irq_chk(1'b0, 3'h4, 1'b1);
        irq <= '0;
        wr(OFS_FLG, 32'h0000_03C0, 4'h3);
    endtask

    // stack pointer choice and the interrupt clears
    task automatic t_stack;
        wr(OFS_USP, 32'h0000_1234, 4'h3);
        wr(OFS_ISP, 32'h0000_5678, 4'h3);
        `CHK("sp user", 16'h1234, stack_pointer)
        int_pulse(1'b0, 6'h20);
        `CHK("flags v32", 11'h380, processor_flag_register)
        wr(OFS_FLG, 32'h0000_03C0, 4'h3);
        int_pulse(1'b0, 6'h1F);
        `CHK("flags v31", 11'h300, processor_flag_register)
        `CHK("sp irq", 16'h5678, stack_pointer)
        wr(OFS_FLG, 32'h0000_03C0, 4'h3);
        int_pulse(1'b1, 6'h00);
        `CHK("flags ack", 11'h300, processor_flag_register)
    endtask

    // condition flags from alu results
    task automatic t_alu;
        alu_op(1'b1, 1'b0, 16'h0000);
        `CHK("zero carry", 11'h305, processor_flag_register)
        alu_op(1'b0, 1'b1, 16'h8000);
        `CHK("sign ovf", 11'h328, processor_flag_register)
        rd_chk("flags", OFS_FLG, 32'h0000_0328);
    endtask

    // core port: long pair, byte lane, active stack alias, pc, registered reads
    task automatic t_core;
        core_w(SEL_D0, SZ_LONG, 32'h1357_2468);
        core_w(SEL_D0, SZ_LO, 32'h0000_00AB);
        core_w(SEL_SP, SZ_WORD, 32'h0000_4321);
        core_w(SEL_PC, SZ_LO, 32'h0001_2345);
        core_rd_chk("core pair", SEL_D0, SZ_LONG, 32'h1357_24AB);
        core_rd_chk("core hi", SEL_D0, SZ_HI, 32'h0000_0024);
        core_rd_chk("core sp", SEL_SP, SZ_WORD, 32'h0000_4321);
        core_rd_chk("core pc", SEL_PC, SZ_WORD, 32'h0001_2345);
        `CHK("sp isp", 16'h4321, stack_pointer)
        `CHK("pc core", 20'h1_2345, program_counter)
    endtask

    // reset, then scenarios in order
    initial begin
        resetn = 1'b0;
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        core_wr = '0;
        core_rd_sel = SEL_D0;
        core_rd_size = SZ_WORD;
        alu = '0;
        irq = '0;
        hw_ack = 1'b0;
        sw_int = 1'b0;
        sw_vec = 6'h00;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_words();
        t_long();
        t_bank();
        t_flags_irq();
        t_stack();
        t_alu();
        t_core();
        complete_run();
    end
endmodule
